/* design/positioning_sequencer.sv */
// Purpose: Runs positioning operations from a 64-entry table of data sets,
//          chaining linked entries and dwelling between linked-2 entries.
// Assumes: A motion generator on the same clock takes each segment and
//          pulses i_seg_done when it ends; start and select arrive on pins
//          (direct I/O) or by a control register write (network I/O).
// Notes: Operation
// Operation
// - Six select bits form data number 0 to 63, bit0 least significant.
// - A single-motion data set makes one move and then stops.
// - Network start and select in one write still start that data.
// - Ready drops on accepting start; host then releases start.
// - Ready returns once the whole chain has finished.
// - Linked-motion entry runs into the next number without stopping.
// - Chain ends stopped after first single or push entry finishes.
// - At most four data sets per chain, both linked kinds counted.
// - Five or more chained sets raise data error at start.
// - Plain linked direction change raises data error during the move.
// - Entry 63 never chains on to entry 0.
// - Linked chain uses acceleration and deceleration of its start entry.
// - Push entry reached by a link runs at starting speed.
// - Linked-motion 2 may join entries of differing direction.
// - After each linked-2 move, hold for dwell then start next entry.
// - At dwell begin, motion-active drops while ready stays low.
// - At dwell end, motion-active rises as the next entry starts.
`timescale 1ns/1ps
`default_nettype none
module positioning_sequencer
    import pos_seq_pkg::*;
#(
    parameter int DWELL_TICKS = DWELL_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [5:0] i_data_select,
    input wire logic i_start,
    input wire logic signed [31:0] i_cur_pos,
    input wire logic i_seg_done,
    output logic o_ready,
    output logic o_move,
    output logic o_data_error,
    output logic o_seg_start,
    output logic o_seg_abort,
    output logic [31:0] o_seg_target,
    output logic [15:0] o_seg_speed,
    output logic [15:0] o_seg_accel,
    output logic [15:0] o_seg_decel,
    output logic o_seg_absolute_target_mode,
    output logic o_seg_continue,
    output logic o_seg_push,
    output logic o_seg_push_start_speed,
    output logic [9:0] o_seg_push_current,
    output logic [5:0] o_cur_no
);

    // Stored data sets.
    logic [31:0] pos_mem [DATA_SETS];
    logic [15:0] speed_mem [DATA_SETS];
    logic [15:0] accel_mem [DATA_SETS];
    logic [15:0] decel_mem [DATA_SETS];
    logic [15:0] dwell_mem [DATA_SETS];
    logic abs_mem [DATA_SETS];
    op_func_t func_mem [DATA_SETS];
    logic [9:0] push_mem [DATA_SETS];

    // Sequencer state.
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [5:0] cur_no_r;
    logic [5:0] chk_no_r;
    logic [2:0] chk_cnt_r;
    logic cur_dir_neg_r;
    logic linked_in_r;
    logic [15:0] chain_acc_r;
    logic [15:0] chain_dec_r;

    // Pin synchronisers and dwell timer handshake.
    logic [5:0] sel_s1_r;
    logic [5:0] sel_s2_r;
    logic start_s1_r;
    logic start_s2_r;
    logic start_s3_r;
    logic dwell_done;

    // Bus decode; a request is taken at the edge where waitrequest is low.
    wire bus_req = i_avs_read | i_avs_write;
    wire bus_take = bus_req & ~o_avs_waitrequest;
    wire bus_wr = i_avs_write & bus_take;
    wire [11:0] tbl_off = i_avs_address - TABLE_BASE;
    wire tbl_hit = (i_avs_address >= TABLE_BASE) && (i_avs_address <= TABLE_LAST) && (i_avs_address[1:0] == 2'b00);
    wire [5:0] tbl_idx = tbl_off[9:4];
    wire [1:0] tbl_word = tbl_off[3:2];
    wire tbl_we = bus_wr & tbl_hit;
    wire ctrl_we = bus_wr & (i_avs_address == CTRL_OFS);
    wire clr_we = bus_wr & (i_avs_address == ALARM_CLR_OFS) & i_avs_writedata[ALARM_CLR_BIT];

    // network start
    // Start bit and selection in one write count as one start request.
    wire net_start = ctrl_we & i_avs_writedata[CTRL_START_BIT];
    wire [5:0] net_sel = i_avs_writedata[CTRL_SEL_LSB +: NUM_W];

    // pin start edge
    // Rising edge of the synchronised start; selection was settled before it.
    wire pin_start = start_s2_r & ~start_s3_r;
    wire start_req = net_start | pin_start;
    wire [5:0] start_no = net_start ? net_sel : sel_s2_r;

    // Readback of the addressed data set word.
    wire [31:0] tbl_rd_pos = pos_mem[tbl_idx];
    wire [31:0] tbl_rd_sa = {accel_mem[tbl_idx], speed_mem[tbl_idx]};
    wire [31:0] tbl_rd_dd = {dwell_mem[tbl_idx], decel_mem[tbl_idx]};
    wire [31:0] tbl_rd_mode = {6'h00, push_mem[tbl_idx], 13'h0000, abs_mem[tbl_idx], func_mem[tbl_idx]};
    wire [31:0] tbl_rd = (tbl_word == WORD_POS) ? tbl_rd_pos :
                         (tbl_word == WORD_SPD_ACC) ? tbl_rd_sa :
                         (tbl_word == WORD_DEC_DWELL) ? tbl_rd_dd : tbl_rd_mode;
    wire [31:0] status_word = {9'h000, state_r, 1'b0, chk_cnt_r, 2'b00, cur_no_r, 5'h00, o_data_error, o_move, o_ready};
    wire [31:0] ctrl_word = {18'h00000, sel_s2_r, 7'h00, start_s2_r};
    wire [31:0] rd_mux = tbl_hit ? tbl_rd :
                         (i_avs_address == STATUS_OFS) ? status_word :
                         (i_avs_address == CTRL_OFS) ? ctrl_word : 32'h0000_0000;

    // Chain helpers; entry 63 is never treated as linking onward.
    // no wrap past 63
    wire chk_links = ((func_mem[chk_no_r] == FUNC_LINKED) || (func_mem[chk_no_r] == FUNC_LINKED2)) && (chk_no_r != LAST_NO);
    wire cur_linked = (func_mem[cur_no_r] == FUNC_LINKED) && (cur_no_r != LAST_NO);
    wire cur_linked2 = (func_mem[cur_no_r] == FUNC_LINKED2) && (cur_no_r != LAST_NO);
    wire [5:0] next_no = cur_no_r + 6'h01;
    // Direction: absolute targets compare with where the motor stands now.
    wire next_dir_neg = abs_mem[next_no] ? ($signed(pos_mem[next_no]) < i_cur_pos) : pos_mem[next_no][31];
    wire cur_dir_neg = abs_mem[cur_no_r] ? ($signed(pos_mem[cur_no_r]) < i_cur_pos) : pos_mem[cur_no_r][31];

    // Segment launch decode.
    logic seg_load;
    logic [5:0] seg_no;
    logic seg_via_link;
    logic seg_new_rates;

    // data set table
    // One flop bank per entry; only the addressed entry takes a bus write.
    for (genvar g = 0; g < DATA_SETS; g++) begin : g_entry
        wire ent_we = tbl_we && (tbl_idx == 6'(g));
        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                pos_mem[g] <= RST_POS;
                speed_mem[g] <= RST_SPEED;
                accel_mem[g] <= RST_RATE;
                decel_mem[g] <= RST_RATE;
                dwell_mem[g] <= RST_DWELL;
                abs_mem[g] <= 1'b0;
                func_mem[g] <= FUNC_SINGLE;
                push_mem[g] <= RST_PUSH;
            end else if (ent_we) begin
                case (tbl_word)
                    WORD_POS: begin
                        pos_mem[g] <= i_avs_writedata;
                    end
                    WORD_SPD_ACC: begin
                        speed_mem[g] <= i_avs_writedata[15:0];
                        accel_mem[g] <= i_avs_writedata[31:16];
                    end
                    WORD_DEC_DWELL: begin
                        decel_mem[g] <= i_avs_writedata[15:0];
                        dwell_mem[g] <= i_avs_writedata[31:16];
                    end
                    default: begin
                        func_mem[g] <= op_func_t'(i_avs_writedata[MODE_FUNC_LSB +: 2]);
                        abs_mem[g] <= i_avs_writedata[MODE_ABS_BIT];
                        push_mem[g] <= i_avs_writedata[MODE_PUSH_LSB +: 10];
                    end
                endcase
            end
        end
    end

    // Bus slave: one wait cycle per request, read data captured as it drops.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
            if (i_avs_read & o_avs_waitrequest) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    // Pins come from outside the clock domain: two flops before any use.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_s1_r <= 6'h00;
            sel_s2_r <= 6'h00;
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_s3_r <= 1'b0;
        end else begin
            sel_s1_r <= i_data_select;
            sel_s2_r <= sel_s1_r;
            start_s1_r <= i_start;
            start_s2_r <= start_s1_r;
            start_s3_r <= start_s2_r;
        end
    end

    // Next state and segment launch decision.
    always_comb begin
        state_nxt = state_r;
        seg_load = 1'b0;
        seg_no = cur_no_r;
        seg_via_link = 1'b0;
        seg_new_rates = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // host waits ready
                // A start is only heard while ready is high.
                if (start_req) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (chk_links && (chk_cnt_r == MAX_CHAIN)) begin
                    state_nxt = ST_ALARM;
                end else if (!chk_links) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                seg_load = 1'b1;
                seg_new_rates = 1'b1;
                state_nxt = ST_MOVE;
            end
            ST_MOVE: begin
                if (i_seg_done) begin
                    if (cur_linked) begin
                        if (next_dir_neg != cur_dir_neg_r) begin
                            state_nxt = ST_ALARM;
                        end else begin
                            seg_load = 1'b1;
                            seg_no = next_no;
                            seg_via_link = 1'b1;
                        end
                    end else if (cur_linked2) begin
                        state_nxt = ST_DWELL;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_DWELL: begin
                if (dwell_done) begin
                    seg_load = 1'b1;
                    seg_no = next_no;
                    seg_via_link = 1'b1;
                    seg_new_rates = 1'b1;
                    state_nxt = ST_MOVE;
                end
            end
            ST_ALARM: begin
                if (clr_we) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            cur_no_r <= 6'h00;
            chk_no_r <= 6'h00;
            chk_cnt_r <= 3'h0;
            cur_dir_neg_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if ((state_r == ST_IDLE) && start_req) begin
                cur_no_r <= start_no;
                chk_no_r <= start_no;
                chk_cnt_r <= CHAIN_ONE;
            end
            if ((state_r == ST_CHECK) && chk_links && (chk_cnt_r != MAX_CHAIN)) begin
                chk_no_r <= chk_no_r + 6'h01;
                chk_cnt_r <= chk_cnt_r + 3'h1;
            end
            if (seg_load) begin
                cur_no_r <= seg_no;
                cur_dir_neg_r <= (seg_no == cur_no_r) ? cur_dir_neg : next_dir_neg;
            end
        end
    end

    // Handshake outputs to the host.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_ready <= 1'b1;
            o_move <= 1'b0;
            o_data_error <= 1'b0;
            o_seg_abort <= 1'b0;
            o_cur_no <= 6'h00;
        end else begin
            o_cur_no <= cur_no_r;
            o_seg_abort <= (state_nxt == ST_ALARM) && (state_r != ST_ALARM);
            if ((state_r == ST_IDLE) && start_req) begin
                o_ready <= 1'b0;
            end else if ((state_nxt == ST_IDLE) && (state_r != ST_IDLE)) begin
                o_ready <= 1'b1;
            end
            if (seg_load) begin
                o_move <= 1'b1;
            end else if (state_nxt != ST_MOVE) begin
                o_move <= 1'b0;
            end
            // Alarm is only raised outside ST_ALARM and only cleared inside it.
            if (state_nxt == ST_ALARM) begin
                o_data_error <= 1'b1;
            end else if (state_r == ST_ALARM) begin
                o_data_error <= 1'b0;
            end
        end
    end

    // Segment command to the motion generator, loaded as each entry starts.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_seg_start <= 1'b0;
            o_seg_target <= 32'h0000_0000;
            o_seg_speed <= 16'h0000;
            o_seg_accel <= 16'h0000;
            o_seg_decel <= 16'h0000;
            o_seg_absolute_target_mode <= 1'b0;
            o_seg_continue <= 1'b0;
            o_seg_push <= 1'b0;
            o_seg_push_start_speed <= 1'b0;
            o_seg_push_current <= 10'h000;
        end else begin
            o_seg_start <= seg_load;
            if (seg_load) begin
                o_seg_target <= pos_mem[seg_no];
                o_seg_speed <= speed_mem[seg_no];
                // chain start rates
                // Rates change only after a full stop, never mid run-on.
                o_seg_accel <= seg_new_rates ? accel_mem[seg_no] : chain_acc_r;
                o_seg_decel <= seg_new_rates ? decel_mem[seg_no] : chain_dec_r;
                o_seg_absolute_target_mode <= abs_mem[seg_no];
                o_seg_continue <= (func_mem[seg_no] == FUNC_LINKED) && (seg_no != LAST_NO);
                o_seg_push <= (func_mem[seg_no] == FUNC_PUSH);
                o_seg_push_start_speed <= (func_mem[seg_no] == FUNC_PUSH) && seg_via_link;
                o_seg_push_current <= push_mem[seg_no];
            end
        end
    end

    // Rates held for the run-on part of a chain.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            chain_acc_r <= 16'h0000;
            chain_dec_r <= 16'h0000;
        end else if (seg_load && seg_new_rates) begin
            chain_acc_r <= accel_mem[seg_no];
            chain_dec_r <= decel_mem[seg_no];
        end
    end

    // Dwell starts on the cycle the linked-2 move is reported done.
    dwell_timer #(
        .TICK_CYCLES(DWELL_TICKS)
    ) u_dwell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_load((state_r == ST_MOVE) && (state_nxt == ST_DWELL)),
        .i_dwell_ms(dwell_mem[cur_no_r]),
        .o_expired(dwell_done)
    );

endmodule : positioning_sequencer
`default_nettype wire

/* design/pos_seq_pkg.sv */
// Purpose: Shared constants and types for the positioning sequencer.
// Assumes: 40 MHz core clock, Avalon-MM register access with 32-bit data.
// Notes: Byte addresses; every register occupies one aligned word.
package pos_seq_pkg;

    // Table geometry.
    localparam int DATA_SETS = 64;
    localparam int NUM_W = 6;
    localparam logic [5:0] LAST_NO = 6'h3f;
    localparam logic [2:0] MAX_CHAIN = 3'h4;
    localparam logic [2:0] CHAIN_ONE = 3'h1;

    // Operation function encoding held in each stored data set.
    typedef enum logic [1:0] {
        FUNC_SINGLE  = 2'b00,
        FUNC_LINKED  = 2'b01,
        FUNC_LINKED2 = 2'b10,
        FUNC_PUSH    = 2'b11
    } op_func_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_LOAD  = 3'b010,
        ST_MOVE  = 3'b011,
        ST_DWELL = 3'b100,
        ST_ALARM = 3'b101
    } seq_state_t;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] ALARM_CLR_OFS = 12'h008;
    localparam logic [11:0] TABLE_BASE = 12'h100;
    localparam logic [11:0] TABLE_LAST = 12'h4fc;

    // Word index inside one 16-byte data set window.
    localparam logic [1:0] WORD_POS = 2'h0;
    localparam logic [1:0] WORD_SPD_ACC = 2'h1;
    localparam logic [1:0] WORD_DEC_DWELL = 2'h2;
    localparam logic [1:0] WORD_MODE = 2'h3;

    // Field positions.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SEL_LSB = 8;
    localparam int MODE_FUNC_LSB = 0;
    localparam int MODE_ABS_BIT = 2;
    localparam int MODE_PUSH_LSB = 16;
    localparam int ALARM_CLR_BIT = 0;

    // Values after reset of each stored data set.
    localparam logic [31:0] RST_POS = 32'h0000_0000;
    localparam logic [15:0] RST_SPEED = 16'h03e8;
    localparam logic [15:0] RST_RATE = 16'h03e8;
    localparam logic [15:0] RST_DWELL = 16'h0000;
    localparam logic [9:0] RST_PUSH = 10'h000;

    // Dwell time base: one count is one millisecond.
    localparam int CLK_FREQ_MHZ = 40;
    localparam int DWELL_UNIT_US = 1000;
    localparam int DWELL_TICK_CYCLES = DWELL_UNIT_US * CLK_FREQ_MHZ;

endpackage : pos_seq_pkg

/* design/dwell_timer.sv */
// Purpose: Millisecond dwell timer with a one-cycle expiry pulse.
// Assumes: i_load is a one-cycle pulse from the sequencer on the same clock.
// Notes: A dwell of zero expires two cycles after the load.
`timescale 1ns/1ps
`default_nettype none
module dwell_timer #(
    parameter int TICK_CYCLES = 40000
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [15:0] i_dwell_ms,
    output logic o_expired
);

    logic active_r;
    logic [15:0] ms_left_r;
    logic [31:0] tick_cnt_r;
    logic tick;

    // Millisecond enable, restarted on each load so every dwell is full length.
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    // Count milliseconds down; expiry is a registered pulse.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            active_r <= 1'b0;
            ms_left_r <= 16'h0000;
            tick_cnt_r <= 32'h0000_0000;
            o_expired <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_load) begin
                active_r <= 1'b1;
                ms_left_r <= i_dwell_ms;
                tick_cnt_r <= 32'h0000_0000;
            end else if (active_r) begin
                if (ms_left_r == 16'h0000) begin
                    active_r <= 1'b0;
                    o_expired <= 1'b1;
                end else if (tick) begin
                    tick_cnt_r <= 32'h0000_0000;
                    ms_left_r <= ms_left_r - 16'h0001;
                end else begin
                    tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
                end
            end
        end
    end

endmodule : dwell_timer
`default_nettype wire

/* verif/pos_seq_assertions.sv */
// Purpose: Port-level timing checks for the positioning sequencer.
// Assumes: One clock domain with a synchronous reset.
// Notes: Bound to every instance of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pos_seq_checker
    import pos_seq_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_seg_done,
    input wire logic o_ready,
    input wire logic o_move,
    input wire logic o_data_error,
    input wire logic o_seg_start,
    input wire logic o_seg_abort,
    input wire logic o_seg_continue,
    input wire logic [31:0] o_seg_target,
    input wire logic [15:0] o_seg_accel,
    input wire logic [5:0] o_cur_no
);
    // Every check shares one clock, and reset silences them all.
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_idle_still: assert property (o_ready |-> !o_move)
        else $error("motion while ready");
    a_accept_seg: assert property ($fell(o_ready) |-> ##[1:12] (o_seg_start || o_data_error))
        else $error("no segment after accept");
    a_link_runon: assert property (i_seg_done && o_move && o_seg_continue |=> (o_seg_start && o_move) || o_data_error)
        else $error("linked entry stopped");
    a_stop_end: assert property (i_seg_done && o_move && !o_seg_continue |=> !o_move)
        else $error("motion kept after stop entry");
    a_rise_start: assert property ($rose(o_move) |-> o_seg_start)
        else $error("motion rose without segment");
    a_error_idle: assert property (o_data_error |-> !o_move && !o_ready)
        else $error("alarm while running or ready");
    a_fields_hold: assert property (!o_seg_start |-> $stable(o_seg_target) && $stable(o_seg_accel))
        else $error("segment fields changed");
    a_last_alone: assert property (o_move && o_cur_no == LAST_NO |-> !o_seg_continue)
        else $error("last entry runs on");
    a_abort_quiet: assert property (o_seg_abort |=> !o_seg_abort && !o_seg_start)
        else $error("segment after abort");
    c_alarm: cover property ($rose(o_data_error));
    c_link: cover property (i_seg_done && o_seg_continue);
    c_dwell: cover property ($fell(o_move) && !o_ready);
endmodule : pos_seq_checker
bind positioning_sequencer pos_seq_checker u_pos_seq_checker (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_seg_done(i_seg_done), .o_ready(o_ready), .o_move(o_move), .o_data_error(o_data_error),
    .o_seg_start(o_seg_start), .o_seg_abort(o_seg_abort), .o_seg_continue(o_seg_continue),
    .o_seg_target(o_seg_target), .o_seg_accel(o_seg_accel), .o_cur_no(o_cur_no));
`default_nettype wire

/* verif/host_pin_model.sv */
// Purpose: Host that starts operations over the select and start pins.
// Assumes: A one-cycle go request from the bench.
// Notes: Select leads start by a cycle so the synchronisers never split them.
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic [5:0] i_no,
    input wire logic i_ready,
    output logic [5:0] o_sel,
    output logic o_start
);
    logic [1:0] step_r = 2'h0;
    initial o_sel = 6'h00;
    initial o_start = 1'b0;
    always @(posedge i_core_clk) begin
        if (step_r == 2'h0 && i_go && i_ready) begin
            o_sel <= i_no;
            step_r <= 2'h1;
        end else if (step_r == 2'h1) begin
            o_start <= 1'b1;
            step_r <= 2'h2;
        end else if (step_r == 2'h2 && !i_ready) begin
            o_start <= 1'b0;
            step_r <= 2'h0;
        end
    end
endmodule : host_pin_model
`default_nettype wire

/* verif/positioning_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the positioning sequencer.
// Assumes: Motion segments end six cycles after they start.
// Notes: Dwell tick shortened to four cycles.
`timescale 1ns/1ps
`default_nettype none
module positioning_sequencer_tb_top;
    import pos_seq_pkg::*;
    logic clk = 0, rst = 1, rd = 0, wr = 0, seg_done = 0, go = 0;
    logic start, wq, ready, move, err, sst, cont, pss, psh;
    logic [11:0] adr = 0;
    logic [31:0] wd = 0, rdat, q, tgt, cp = 0;
    logic [15:0] acc;
    logic [5:0] sel, cno, no = 0;
    logic [2:0] mg = 0;
    int n_mismatch = 0, comparisons = 0, cyc = 0, segs = 0, gap = 0, s0, g0;
    always #12.5 clk = ~clk;
    positioning_sequencer #(.DWELL_TICKS(4)) u_positioning_sequencer (.i_core_clk(clk), .i_rst(rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_data_select(sel), .i_start(start), .i_cur_pos(cp),
        .i_seg_done(seg_done), .o_ready(ready), .o_move(move), .o_data_error(err), .o_seg_start(sst),
        .o_seg_abort(), .o_seg_target(tgt), .o_seg_speed(), .o_seg_accel(acc), .o_seg_decel(),
        .o_seg_absolute_target_mode(), .o_seg_continue(cont), .o_seg_push(psh), .o_seg_push_start_speed(pss),
        .o_seg_push_current(), .o_cur_no(cno));
    host_pin_model u_host_pin_model (.i_core_clk(clk), .i_go(go), .i_no(no), .i_ready(ready),
        .o_sel(sel), .o_start(start));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    // Motion stand-in, segment and dwell counters, and the hang limit.
    always @(posedge clk) begin
        seg_done <= (mg == 3'h1);
        mg <= sst ? 3'h5 : (mg != 3'h0 ? mg - 3'h1 : 3'h0);
        if (sst) segs <= segs + 1;
        if (!move && !ready && !err) gap <= gap + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // The request stays put until waitrequest is sampled low at a rising edge.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin @(posedge clk); end while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic ent(input logic [5:0] n, input logic [31:0] pos, input logic [31:0] w3);
        bus(1'b1, TABLE_BASE + {2'h0, n, 4'h0}, pos);
        bus(1'b1, TABLE_BASE + {2'h0, n, 4'hc}, w3);
    endtask : ent
    // Start by pin or by control write, wait for the end, then clear any alarm.
    task automatic run(input logic pin, input logic [5:0] n, input int exp_segs, input logic exp_err);
        s0 = segs;
        if (pin) begin
            no <= n;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
        end else bus(1'b1, CTRL_OFS, {18'h0, n, 8'h01});
        do begin @(negedge clk); end while (ready === 1'b1);
        while (!ready && !err) begin @(negedge clk); end
        repeat (2) @(negedge clk);
        chk("segments", segs - s0, exp_segs);
        chk("alarm", {31'h0, err}, {31'h0, exp_err});
        if (err) bus(1'b1, ALARM_CLR_OFS, 32'h1);
        repeat (2) @(negedge clk);
        chk("ready", {31'h0, ready}, 32'h1);
        $display("test from entry %0d done", n);
    endtask : run
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, TABLE_BASE + 12'h004, 32'h0);
        chk("rates_reset", q, 32'h03e8_03e8);
        bus(1'b0, 12'h00c, 32'h0);
        chk("unmapped", q, 32'h0);
        ent(6'd5, 32'h64, 32'h0);
        run(1'b0, 6'd5, 1, 1'b0);
        chk("single_target", tgt, 32'h64);
        bus(1'b1, 12'h3a4, {16'h0011, 16'h03e8});
        ent(6'd42, 32'h10, 32'h1);
        ent(6'd43, 32'h20, 32'h3);
        run(1'b1, 6'd42, 2, 1'b0);
        chk("link_target", tgt, 32'h20);
        chk("link_accel", {16'h0, acc}, 32'h0011);
        chk("push_slow", {31'h0, pss}, 32'h1);
        chk("push_seg", {31'h0, psh}, 32'h1);
        chk("cur_no", {26'h0, cno}, 32'h2b);
        ent(6'd10, 32'h10, 32'h2);
        bus(1'b1, 12'h1a8, {16'h0002, 16'h03e8});
        ent(6'd11, 32'hffff_fff0, 32'h0);
        g0 = gap;
        run(1'b0, 6'd10, 2, 1'b0);
        chk("dwell_gap", {31'h0, (gap - g0) >= 8}, 32'h1);
        for (int i = 20; i < 24; i++) ent(i[5:0], 32'h1, 32'h1);
        ent(6'd24, 32'h1, 32'h0);
        run(1'b0, 6'd20, 0, 1'b1);
        run(1'b0, 6'd21, 4, 1'b0);
        ent(6'd30, 32'h5, 32'h1);
        ent(6'd31, 32'hffff_fffb, 32'h0);
        run(1'b0, 6'd30, 1, 1'b1);
        ent(6'd63, 32'h5, 32'h1);
        run(1'b0, 6'd63, 1, 1'b0);
        chk("last_cont", {31'h0, cont}, 32'h0);
        // Absolute entry 34 aims below where the motor stands, so the link reverses.
        ent(6'd33, 32'h5, 32'h1);
        ent(6'd34, 32'h3, 32'h4);
        cp <= 32'h10;
        run(1'b0, 6'd33, 1, 1'b1);
        report_and_stop();
    end
endmodule : positioning_sequencer_tb_top
`default_nettype wire
